/* rtl/adcsq_params.svh */
/*
  Constants of the converter sequencer and digital comparator block:
  sizes, register offsets, field positions and reset values.
  Assumes it is included by bare name from files that need the numbers.
*/
`ifndef ADCSQ_PARAMS_SVH
`define ADCSQ_PARAMS_SVH

// Sizes
`define ADCSQ_NSEQ 4
`define ADCSQ_NSTEP 8
`define ADCSQ_CAP0 4'h8
`define ADCSQ_CAP1 4'h4
`define ADCSQ_CAP2 4'h4
`define ADCSQ_CAP3 4'h1
`define ADCSQ_TEMP_SEL 4'h8
`define ADCSQ_AVG_MAX 3'h6

// Global register byte offsets
`define ADCSQ_OFF_ENABLE 8'h00
`define ADCSQ_OFF_PROCTRIG 8'h04
`define ADCSQ_OFF_AVG 8'h08
`define ADCSQ_OFF_IRQMASK 8'h0C
`define ADCSQ_OFF_IRQRAW 8'h10
`define ADCSQ_OFF_IRQMSK 8'h14
`define ADCSQ_OFF_OVF 8'h18
`define ADCSQ_OFF_UNF 8'h1C
`define ADCSQ_OFF_CMPSTS 8'h20
`define ADCSQ_OFF_CMPRST 8'h24

// Windows: addr[7:6] picks window, addr[5:4] unit, addr[3:2] register
`define ADCSQ_WIN_SEQ 2'h1
`define ADCSQ_WIN_CMP 2'h2
`define ADCSQ_SEQ_STEPCH 2'h0
`define ADCSQ_SEQ_CTL 2'h1
`define ADCSQ_SEQ_CFG 2'h2
`define ADCSQ_SEQ_FIFO 2'h3
`define ADCSQ_CMP_CFG 2'h0
`define ADCSQ_CMP_REF 2'h1

// Field positions
`define ADCSQ_CTL_IRQ_LSB 2'h1
`define ADCSQ_CTL_CMP_LSB 2'h2
`define ADCSQ_CFG_PRI_LSB 4
`define ADCSQ_CMP_IRQ_LSB 8
`define ADCSQ_REF_HIGH_LSB 16
`define ADCSQ_CMPRST_IRQ_LSB 8

// Reset values
`define ADCSQ_RST_ZERO32 32'h0000_0000
`define ADCSQ_RST_CTL 24'h00_0000
`define ADCSQ_RST_REF 12'h000

`endif

/* rtl/adcsq_pkg.sv */
/*
  Types of the converter sequencer and digital comparator block.
  Assumes adcsq_params.svh supplies the numbers; this holds types only.
*/
package adcsq_pkg;

  // Comparator condition codes, shared by the fault and interrupt fields
  typedef enum logic [3:0] {
    fault_trigger_never = 4'h0,
    fault_low_band_continuous = 4'h1,
    fault_low_band_single_shot = 4'h2,
    fault_low_band_hyst_continuous = 4'h3,
    fault_low_band_hyst_single_shot = 4'h4,
    fault_mid_band_continuous = 4'h5,
    fault_mid_band_single_shot = 4'h6,
    fault_high_band_continuous = 4'h7,
    fault_high_band_single_shot = 4'h8,
    fault_high_band_hyst_continuous = 4'h9,
    fault_high_band_hyst_single_shot = 4'hA
  } adcsq_cond_e;

  // Trigger source codes
  typedef enum logic [2:0] {
    trigProcessor = 3'h0,
    trigAlways = 3'h1,
    trigExt0 = 3'h2,
    trigExt1 = 3'h3,
    trigExt2 = 3'h4,
    trigExt3 = 3'h5
  } adcsq_trig_e;

  typedef enum logic [1:0] {bandNone, bandLow, bandMid, bandHigh} adcsq_band_e;

  typedef enum logic [1:0] {stIdle, stStart, stWait, stStore} adcsq_state_e;

  typedef struct packed {
    logic [1:0] pri;
    adcsq_trig_e trig;
  } adcsq_seqcfg_s;

  typedef struct packed {
    adcsq_cond_e irqMode;
    adcsq_cond_e faultMode;
  } adcsq_cmpcfg_s;

  typedef struct packed {
    adcsq_band_e prev;
    logic armed;
  } adcsq_hist_s;

endpackage

/* rtl/adcsq_top.sv */
/*
  Sample sequencer control with per-sequence result FIFOs, hardware
  averaging, sequence interrupts and one digital comparator per sequence.
  Assumes a converter core on clk_sys that answers convStart with one
  convDone pulse and valid convData, at least one cycle later, and
  external trigger pins that are asynchronous to clk_sys.
*/
// Local design decisions: the placing of the registers and the plain strobed port.
// Summary of operation
// R1 - Four sequencers of eight, four, four, one steps
// R2 - Step selects any input or temperature sensor
// R3 - Highest priority triggered sequencer converts first
// R4 - Each sequencer has its own trigger source
// R5 - Software trigger starts processor-triggered sequencers
// R6 - Disabled sequencer ignores triggers, captures nothing
// R7 - FIFO overflow and underflow flags, cleared separately
// R8 - Averaging 2x to 64x for all sequencers
// R9 - Sequence interrupt with mask, raw, masked, clear
// R10 - Comparator config has separate fault, interrupt fields
// R11 - Fault field has a never setting
// R12 - Continuous modes fire on every in-band result
// R13 - Single-shot modes fire on entering the band
// R14 - Hysteresis needs opposite band since last firing
// R15 - Interrupt field uses same conditions, independently
// R16 - Comparator status bit-mapped, write mask clears
// R17 - Low at or below low, mid up to high
// R18 - Software resets trigger and interrupt history separately
// R19 - Averaging factor zero means single conversion
// R20 - FIFO depth equals step capacity, in order
// R21 - Interrupt-marked step sets raw status regardless
`timescale 1ns/1ps
`include "adcsq_params.svh"

module adcsq_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic [3:0] extTrig,
  output logic convStart,
  output logic [3:0] convChannel,
  input wire logic convDone,
  input wire logic [11:0] convData,
  output logic [3:0] seqIrq,
  output logic [3:0] pwmFault,
  output logic cmpIrq
);

  localparam logic [3:0] SEQ_CAP [`ADCSQ_NSEQ] = '{`ADCSQ_CAP0, `ADCSQ_CAP1, `ADCSQ_CAP2,
                                                   `ADCSQ_CAP3};
  localparam adcsq_pkg::adcsq_hist_s HIST_RST = '{prev: adcsq_pkg::bandNone, armed: 1'b1};

  // Condition test shared by the fault and interrupt fields
  function automatic logic condHit(input adcsq_pkg::adcsq_cond_e m,
                                   input adcsq_pkg::adcsq_band_e b,
                                   input adcsq_pkg::adcsq_hist_s h);
    logic moved;
    logic hit;
    moved = (b != h.prev);
    case (m)
      adcsq_pkg::fault_low_band_continuous: hit = (b == adcsq_pkg::bandLow);
      adcsq_pkg::fault_low_band_single_shot: hit = (b == adcsq_pkg::bandLow) && moved;
      adcsq_pkg::fault_low_band_hyst_continuous: hit = (b == adcsq_pkg::bandLow) && h.armed;
      adcsq_pkg::fault_low_band_hyst_single_shot: hit = (b == adcsq_pkg::bandLow) && moved
                                                        && h.armed;
      adcsq_pkg::fault_mid_band_continuous: hit = (b == adcsq_pkg::bandMid);
      adcsq_pkg::fault_mid_band_single_shot: hit = (b == adcsq_pkg::bandMid) && moved;
      adcsq_pkg::fault_high_band_continuous: hit = (b == adcsq_pkg::bandHigh);
      adcsq_pkg::fault_high_band_single_shot: hit = (b == adcsq_pkg::bandHigh) && moved;
      adcsq_pkg::fault_high_band_hyst_continuous: hit = (b == adcsq_pkg::bandHigh) && h.armed;
      adcsq_pkg::fault_high_band_hyst_single_shot: hit = (b == adcsq_pkg::bandHigh) && moved
                                                         && h.armed;
      default: hit = 1'b0; // Never setting and unused codes
    endcase
    return hit;
  endfunction

  // History after a compared result: band remembered, hysteresis disarmed on a hit, re-armed by the opposite band
  function automatic adcsq_pkg::adcsq_hist_s histNext(input adcsq_pkg::adcsq_hist_s h,
                                                      input adcsq_pkg::adcsq_cond_e m,
                                                      input adcsq_pkg::adcsq_band_e b,
                                                      input logic hit);
    adcsq_pkg::adcsq_hist_s n;
    logic lowHyst;
    logic highHyst;
    lowHyst = (m == adcsq_pkg::fault_low_band_hyst_continuous) ||
              (m == adcsq_pkg::fault_low_band_hyst_single_shot);
    highHyst = (m == adcsq_pkg::fault_high_band_hyst_continuous) ||
               (m == adcsq_pkg::fault_high_band_hyst_single_shot);
    n.prev = b;
    n.armed = hit ? 1'b0 : (h.armed || (lowHyst && b == adcsq_pkg::bandHigh) ||
                            (highHyst && b == adcsq_pkg::bandLow)); // [R14]
    return n;
  endfunction

  // Software-visible state
  logic [3:0] seqEn_r;
  logic [2:0] avgFactor_r;
  logic [3:0] irqMask_r;
  logic [3:0] irqRaw_r;
  logic [3:0] ovf_r;
  logic [3:0] unf_r;
  logic [3:0] cmpSts_r;
  logic [3:0] pend_r;
  logic [31:0] stepCh_r [`ADCSQ_NSEQ];
  logic [23:0] stepCtl_r [`ADCSQ_NSEQ];
  adcsq_pkg::adcsq_seqcfg_s seqCfg_r [`ADCSQ_NSEQ];
  adcsq_pkg::adcsq_cmpcfg_s cmpCfg_r [`ADCSQ_NSEQ];
  logic [11:0] lowRef_r [`ADCSQ_NSEQ];
  logic [11:0] highRef_r [`ADCSQ_NSEQ];
  adcsq_pkg::adcsq_hist_s faultHist_r [`ADCSQ_NSEQ];
  adcsq_pkg::adcsq_hist_s irqHist_r [`ADCSQ_NSEQ];
  logic [11:0] fifoMem_r [`ADCSQ_NSEQ][`ADCSQ_NSTEP];
  logic [2:0] wrPtr_r [`ADCSQ_NSEQ];
  logic [2:0] rdPtr_r [`ADCSQ_NSEQ];
  logic [3:0] count_r [`ADCSQ_NSEQ];
  // Engine and output state
  adcsq_pkg::adcsq_state_e state_r;
  logic [1:0] curSeq_r;
  logic [2:0] curStep_r;
  logic [6:0] avgCnt_r;
  logic [17:0] acc_r;
  logic convStart_r;
  logic [3:0] convChannel_r;
  logic [31:0] rdata_r;
  logic [3:0] seqIrq_r;
  logic [3:0] pwmFault_r;
  logic cmpIrq_r;
  logic [3:0] trigMeta_r;
  logic [3:0] trigSync_r;
  logic [3:0] trigLast_r;
  // Next values of the per-sequence flags
  logic [3:0] irqRaw_nxt;
  logic [3:0] ovf_nxt;
  logic [3:0] unf_nxt;
  logic [3:0] cmpSts_nxt;
  logic [3:0] pend_nxt;
  logic [3:0] pwmFault_nxt;

  // Address decode
  wire logic glbWin = (regAddr[7:6] == 2'h0);
  wire logic seqWin = (regAddr[7:6] == `ADCSQ_WIN_SEQ);
  wire logic cmpWin = (regAddr[7:6] == `ADCSQ_WIN_CMP);
  wire logic [1:0] unitSel = regAddr[5:4];
  wire logic [1:0] unitReg = regAddr[3:2];
  wire logic glbWr = regWr && glbWin;
  wire logic [3:0] procTrig = (glbWr && regAddr == `ADCSQ_OFF_PROCTRIG) ? regWdata[3:0] : 4'h0;
  wire logic [3:0] rawClr = (glbWr && regAddr == `ADCSQ_OFF_IRQRAW) ? regWdata[3:0] : 4'h0;
  wire logic [3:0] ovfClr = (glbWr && regAddr == `ADCSQ_OFF_OVF) ? regWdata[3:0] : 4'h0;
  wire logic [3:0] unfClr = (glbWr && regAddr == `ADCSQ_OFF_UNF) ? regWdata[3:0] : 4'h0;
  wire logic [3:0] cmpClr = (glbWr && regAddr == `ADCSQ_OFF_CMPSTS) ? regWdata[3:0] : 4'h0;
  wire logic cmpRstWr = glbWr && regAddr == `ADCSQ_OFF_CMPRST;
  wire logic [3:0] faultHistClr = cmpRstWr ? regWdata[3:0] : 4'h0; // [R18]
  wire logic [3:0] irqHistClr = cmpRstWr ?
                                regWdata[`ADCSQ_CMPRST_IRQ_LSB +: 4] : 4'h0; // [R18]

  // Trigger pins: two-stage synchroniser, then rising-edge detect on stage two
  wire logic [3:0] extRise = trigSync_r & ~trigLast_r;

  // Arbitration: lowest priority value wins, lower index breaks ties
  logic [3:0] live;
  logic anyReq;
  logic [1:0] grantSeq;
  logic [1:0] bestPri;
  always_comb begin
    anyReq = 1'b0;
    grantSeq = 2'h0;
    bestPri = 2'h3;
    live = pend_r & seqEn_r;
    for (int i = 0; i < `ADCSQ_NSEQ; i++) begin
      if (live[i] && (!anyReq || seqCfg_r[i].pri < bestPri)) begin // [R3]
        anyReq = 1'b1;
        bestPri = seqCfg_r[i].pri;
        grantSeq = 2'(i);
      end
    end
  end
  wire logic grantNow = (state_r == adcsq_pkg::stIdle) && anyReq;

  // Current step: channel, end, interrupt and compare marks
  wire logic [23:0] curCtl = stepCtl_r[curSeq_r];
  wire logic [3:0] curCh = stepCh_r[curSeq_r][{curStep_r, 2'h0} +: 4];
  wire logic [3:0] chSel = (curCh > `ADCSQ_TEMP_SEL) ? `ADCSQ_TEMP_SEL : curCh; // [R2]
  wire logic stepEnd = curCtl[{2'h0, curStep_r}];
  wire logic stepIrq = curCtl[{`ADCSQ_CTL_IRQ_LSB, curStep_r}];
  wire logic stepCmp = curCtl[{`ADCSQ_CTL_CMP_LSB, curStep_r}];
  wire logic lastStep = stepEnd || ({1'b0, curStep_r} == SEQ_CAP[curSeq_r] - 4'h1); // [R1]
  wire logic storeEv = (state_r == adcsq_pkg::stStore) && seqEn_r[curSeq_r]; // [R6]

  // Averaging: factor 0 is one sample, 1..6 are 2x..64x, larger clamps to 64x
  wire logic [2:0] avgEff = (avgFactor_r > `ADCSQ_AVG_MAX) ? `ADCSQ_AVG_MAX : avgFactor_r;
  wire logic [6:0] avgLast = (7'h1 << avgEff) - 7'h1; // [R8] [R19]
  wire logic [17:0] accShift = acc_r >> avgEff;
  wire logic [11:0] resVal = accShift[11:0]; // [R8]

  // Conversion engine: start, wait, accumulate, store, next step
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= adcsq_pkg::stIdle;
      curSeq_r <= 2'h0;
      curStep_r <= 3'h0;
      avgCnt_r <= 7'h00;
      acc_r <= 18'h0_0000;
      convStart_r <= 1'b0;
      convChannel_r <= 4'h0;
    end else begin
      unique case (state_r)
        adcsq_pkg::stIdle: begin
          if (anyReq) begin
            state_r <= adcsq_pkg::stStart;
            curSeq_r <= grantSeq; // [R3]
            curStep_r <= 3'h0;
            acc_r <= 18'h0_0000;
            avgCnt_r <= 7'h00;
          end
        end
        adcsq_pkg::stStart: begin
          convStart_r <= 1'b1;
          convChannel_r <= chSel; // [R2]
          state_r <= adcsq_pkg::stWait;
        end
        adcsq_pkg::stWait: begin
          convStart_r <= 1'b0;
          if (convDone) begin
            acc_r <= acc_r + {6'h00, convData}; // [R8]
            if (avgCnt_r == avgLast) begin
              state_r <= adcsq_pkg::stStore;
            end else begin
              avgCnt_r <= avgCnt_r + 7'h01;
              state_r <= adcsq_pkg::stStart;
            end
          end
        end
        adcsq_pkg::stStore: begin
          acc_r <= 18'h0_0000;
          avgCnt_r <= 7'h00;
          if (lastStep || !seqEn_r[curSeq_r]) begin
            state_r <= adcsq_pkg::stIdle;
          end else begin
            curStep_r <= curStep_r + 3'h1;
            state_r <= adcsq_pkg::stStart;
          end
        end
      endcase
    end
  end

  // Per sequencer: configuration, FIFO, comparator and flag next values
  for (genvar i = 0; i < `ADCSQ_NSEQ; i++) begin : g_seq
    wire logic wrHere = regWr && seqWin && unitSel == 2'(i);
    wire logic wrCmp = regWr && cmpWin && unitSel == 2'(i);
    wire logic popReq = regRd && seqWin && unitSel == 2'(i) && unitReg == `ADCSQ_SEQ_FIFO;
    wire logic hereStore = storeEv && curSeq_r == 2'(i);
    wire logic full = (count_r[i] == SEQ_CAP[i]);
    wire logic empty = (count_r[i] == 4'h0);
    wire logic doPush = hereStore && !stepCmp && !full;
    wire logic doPop = popReq && !empty;
    wire logic cmpEv = hereStore && stepCmp;
    wire logic [2:0] ptrLast = 3'(SEQ_CAP[i] - 4'h1);
    wire adcsq_pkg::adcsq_band_e band = (resVal <= lowRef_r[i]) ? adcsq_pkg::bandLow :
                                        (resVal <= highRef_r[i]) ? adcsq_pkg::bandMid :
                                        adcsq_pkg::bandHigh; // [R17]
    wire logic faultHit = condHit(cmpCfg_r[i].faultMode, band, faultHist_r[i]); // [R12] [R13]
    wire logic irqHit = condHit(cmpCfg_r[i].irqMode, band, irqHist_r[i]); // [R15]
    wire adcsq_pkg::adcsq_trig_e trigSrc = seqCfg_r[i].trig;
    wire logic trigEv = (trigSrc == adcsq_pkg::trigProcessor) ? procTrig[i] : // [R5]
                        (trigSrc == adcsq_pkg::trigAlways) ? 1'b1 :
                        (trigSrc == adcsq_pkg::trigExt0) ? extRise[0] :
                        (trigSrc == adcsq_pkg::trigExt1) ? extRise[1] :
                        (trigSrc == adcsq_pkg::trigExt2) ? extRise[2] :
                        (trigSrc == adcsq_pkg::trigExt3) ? extRise[3] : 1'b0; // [R4]

    // Flags: a setting event wins over a clear in the same cycle
    assign pend_nxt[i] = seqEn_r[i] && (trigEv || (pend_r[i] &&
                         !(grantNow && grantSeq == 2'(i)))); // [R6]
    assign ovf_nxt[i] = (hereStore && !stepCmp && full) || (ovf_r[i] && !ovfClr[i]); // [R7]
    assign unf_nxt[i] = (popReq && empty) || (unf_r[i] && !unfClr[i]); // [R7]
    assign irqRaw_nxt[i] = (hereStore && stepIrq) || (irqRaw_r[i] && !rawClr[i]); // [R21] [R9]
    assign cmpSts_nxt[i] = (cmpEv && irqHit) || (cmpSts_r[i] && !cmpClr[i]); // [R16]
    assign pwmFault_nxt[i] = cmpEv && faultHit; // [R11]

    // Step, control and comparator configuration registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        stepCh_r[i] <= `ADCSQ_RST_ZERO32;
        stepCtl_r[i] <= `ADCSQ_RST_CTL;
        seqCfg_r[i] <= '{pri: 2'(i), trig: adcsq_pkg::trigProcessor};
        cmpCfg_r[i] <= '{irqMode: adcsq_pkg::fault_trigger_never,
                         faultMode: adcsq_pkg::fault_trigger_never};
        lowRef_r[i] <= `ADCSQ_RST_REF;
        highRef_r[i] <= `ADCSQ_RST_REF;
      end else begin
        if (wrHere && unitReg == `ADCSQ_SEQ_STEPCH) stepCh_r[i] <= regWdata;
        if (wrHere && unitReg == `ADCSQ_SEQ_CTL) stepCtl_r[i] <= regWdata[23:0];
        if (wrHere && unitReg == `ADCSQ_SEQ_CFG) begin
          seqCfg_r[i] <= '{pri: regWdata[`ADCSQ_CFG_PRI_LSB +: 2],
                           trig: adcsq_pkg::adcsq_trig_e'(regWdata[2:0])}; // [R4] [R3]
        end
        if (wrCmp && unitReg == `ADCSQ_CMP_CFG) begin
          cmpCfg_r[i] <= '{irqMode: adcsq_pkg::adcsq_cond_e'(regWdata[`ADCSQ_CMP_IRQ_LSB +: 4]),
                           faultMode: adcsq_pkg::adcsq_cond_e'(regWdata[3:0])}; // [R10]
        end
        if (wrCmp && unitReg == `ADCSQ_CMP_REF) begin
          lowRef_r[i] <= regWdata[11:0];
          highRef_r[i] <= regWdata[`ADCSQ_REF_HIGH_LSB +: 12];
        end
      end
    end

    // Result FIFO, depth equal to the step capacity, oldest first
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        wrPtr_r[i] <= 3'h0;
        rdPtr_r[i] <= 3'h0;
        count_r[i] <= 4'h0;
      end else begin
        if (doPush) begin
          fifoMem_r[i][wrPtr_r[i]] <= resVal; // [R20]
          wrPtr_r[i] <= (wrPtr_r[i] == ptrLast) ? 3'h0 : wrPtr_r[i] + 3'h1;
        end
        if (doPop) rdPtr_r[i] <= (rdPtr_r[i] == ptrLast) ? 3'h0 : rdPtr_r[i] + 3'h1;
        count_r[i] <= count_r[i] + {3'h0, doPush} - {3'h0, doPop}; // [R20]
      end
    end

    // Comparator history; a software reset overrides a result in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        faultHist_r[i] <= HIST_RST;
        irqHist_r[i] <= HIST_RST;
      end else begin
        if (faultHistClr[i]) faultHist_r[i] <= HIST_RST; // [R18]
        else if (cmpEv) faultHist_r[i] <= histNext(faultHist_r[i], cmpCfg_r[i].faultMode,
                                                   band, faultHit); // [R14]
        if (irqHistClr[i]) irqHist_r[i] <= HIST_RST; // [R18]
        else if (cmpEv) irqHist_r[i] <= histNext(irqHist_r[i], cmpCfg_r[i].irqMode,
                                                 band, irqHit); // [R15]
      end
    end
  end

  // Read data selection
  wire logic [31:0] glbRd =
    (regAddr == `ADCSQ_OFF_ENABLE) ? {28'h0, seqEn_r} :
    (regAddr == `ADCSQ_OFF_AVG) ? {29'h0, avgFactor_r} :
    (regAddr == `ADCSQ_OFF_IRQMASK) ? {28'h0, irqMask_r} :
    (regAddr == `ADCSQ_OFF_IRQRAW) ? {28'h0, irqRaw_r} : // [R9]
    (regAddr == `ADCSQ_OFF_IRQMSK) ? {28'h0, irqRaw_r & irqMask_r} : // [R9]
    (regAddr == `ADCSQ_OFF_OVF) ? {28'h0, ovf_r} :
    (regAddr == `ADCSQ_OFF_UNF) ? {28'h0, unf_r} :
    (regAddr == `ADCSQ_OFF_CMPSTS) ? {28'h0, cmpSts_r} : 32'h0;
  wire logic [11:0] fifoHead = (count_r[unitSel] == 4'h0) ? 12'h000 :
                               fifoMem_r[unitSel][rdPtr_r[unitSel]];
  wire logic [31:0] seqRd =
    (unitReg == `ADCSQ_SEQ_STEPCH) ? stepCh_r[unitSel] :
    (unitReg == `ADCSQ_SEQ_CTL) ? {8'h00, stepCtl_r[unitSel]} :
    (unitReg == `ADCSQ_SEQ_CFG) ? {12'h000, count_r[unitSel], 10'h000,
                                   seqCfg_r[unitSel].pri, 1'b0, seqCfg_r[unitSel].trig} :
    {20'h0_0000, fifoHead};
  wire logic [31:0] cmpRd =
    (unitReg == `ADCSQ_CMP_CFG) ? {20'h0_0000, cmpCfg_r[unitSel].irqMode, 4'h0,
                                   cmpCfg_r[unitSel].faultMode} :
    (unitReg == `ADCSQ_CMP_REF) ? {4'h0, highRef_r[unitSel], 4'h0, lowRef_r[unitSel]} :
    32'h0;
  wire logic [31:0] rdSel = glbWin ? glbRd : seqWin ? seqRd : cmpWin ? cmpRd : 32'h0;

  // Global control registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seqEn_r <= 4'h0;
      avgFactor_r <= 3'h0;
      irqMask_r <= 4'h0;
    end else begin
      if (glbWr && regAddr == `ADCSQ_OFF_ENABLE) seqEn_r <= regWdata[3:0]; // [R6]
      if (glbWr && regAddr == `ADCSQ_OFF_AVG) avgFactor_r <= regWdata[2:0]; // [R8]
      if (glbWr && regAddr == `ADCSQ_OFF_IRQMASK) irqMask_r <= regWdata[3:0]; // [R9]
    end
  end

  // Flags, read data, synchroniser and registered outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 4'h0;
      ovf_r <= 4'h0;
      unf_r <= 4'h0;
      irqRaw_r <= 4'h0;
      cmpSts_r <= 4'h0;
      pwmFault_r <= 4'h0;
      seqIrq_r <= 4'h0;
      cmpIrq_r <= 1'b0;
      rdata_r <= `ADCSQ_RST_ZERO32;
      trigMeta_r <= 4'h0;
      trigSync_r <= 4'h0;
      trigLast_r <= 4'h0;
    end else begin
      pend_r <= pend_nxt;
      ovf_r <= ovf_nxt;
      unf_r <= unf_nxt;
      irqRaw_r <= irqRaw_nxt;
      cmpSts_r <= cmpSts_nxt;
      pwmFault_r <= pwmFault_nxt;
      seqIrq_r <= irqRaw_r & irqMask_r; // [R9]
      cmpIrq_r <= |cmpSts_r;
      rdata_r <= regRd ? rdSel : 32'h0;
      trigMeta_r <= extTrig;
      trigSync_r <= trigMeta_r;
      trigLast_r <= trigSync_r;
    end
  end

  assign regRdata = rdata_r;
  assign convStart = convStart_r;
  assign convChannel = convChannel_r;
  assign seqIrq = seqIrq_r;
  assign pwmFault = pwmFault_r;
  assign cmpIrq = cmpIrq_r;

endmodule

/* tb/adcsq_properties.sv */
/*
  Port-level assertions for the sequencer and comparator block.
  Assumes a bind onto adcsq_top, one clock and an async active-low reset.
*/
`timescale 1ns/1ps
module adcsq_properties (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic regWr,
  input wire logic convStart,
  input wire logic [3:0] convChannel,
  input wire logic convDone,
  input wire logic [3:0] seqIrq,
  input wire logic [3:0] pwmFault,
  input wire logic cmpIrq
);
  // One domain; checks rest while reset is low
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_startPulse; convStart |=> !convStart; endproperty
  property p_chanHold; !convStart |-> $stable(convChannel); endproperty
  property p_faultCause; |pwmFault |-> $past(convDone, 2); endproperty
  property p_faultPulse; |pwmFault |=> pwmFault == 4'h0; endproperty
  property p_cmpRise; $rose(cmpIrq) |-> $past(convDone, 3); endproperty
  property p_cmpFall; $fell(cmpIrq) |-> $past(regWr, 2) || $past(regWr, 3); endproperty
  property p_seqRise; $rose(|seqIrq) |-> $past(convDone, 3) || $past(regWr, 2); endproperty
  property p_seqFall; $fell(|seqIrq) |-> $past(regWr, 2); endproperty
  a_startPulse: assert property (p_startPulse) else $error("start too long");
  a_chanHold: assert property (p_chanHold) else $error("channel moved");
  a_faultCause: assert property (p_faultCause) else $error("fault without result");
  a_faultPulse: assert property (p_faultPulse) else $error("fault too long");
  a_cmpRise: assert property (p_cmpRise) else $error("cmp irq without result");
  a_cmpFall: assert property (p_cmpFall) else $error("cmp irq dropped alone");
  a_seqRise: assert property (p_seqRise) else $error("seq irq without cause");
  a_seqFall: assert property (p_seqFall) else $error("seq irq dropped alone");
  // Main scenarios reached
  c_fault: cover property (|pwmFault);
  c_cmpIrq: cover property (cmpIrq);
  c_seqClr: cover property ($fell(|seqIrq));
endmodule
bind adcsq_top adcsq_properties i_props (.clk_sys, .rst_n, .regWr, .convStart,
  .convChannel, .convDone, .seqIrq, .pwmFault, .cmpIrq);

/* tb/testbench.sv */
/*
  Self-checking bench: register tasks, a converter core stand-in, scenarios.
  Assumes adcsq_top and the offsets of adcsq_params.svh.
*/
`timescale 1ns/1ps
`include "adcsq_params.svh"
module testbench;
  logic clk_sys = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, convDone = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic [3:0] extTrig = 4'h0, convChannel, seqIrq, pwmFault;
  logic [11:0] convData = 12'h000, cval = 12'h000;
  logic convStart, cmpIrq;
  logic [3:0] chq[$];
  int n_mismatch = 0, cmp_count = 0, nFault = 0;
  adcsq_top i_dut (.clk_sys, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .extTrig,
    .convStart, .convChannel, .convDone, .convData, .seqIrq, .pwmFault, .cmpIrq);
  initial forever #50 clk_sys = ~clk_sys;
  // Core stand-in: result is cval mixed with channel, junk when idle
  always @(posedge clk_sys) begin
    convDone <= convStart;
    convData <= convStart ? (cval ^ {8'h00, convChannel}) : ~convData;
    if (convStart) chq.push_back(convChannel);
    if (pwmFault[0]) nFault++;
  end
  task automatic close_out();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 chk(nm, regRdata, exp);
    @(posedge clk_sys);
  endtask
  task automatic run(input logic [11:0] v, input logic [3:0] trg);
    cval = v;
    wr(`ADCSQ_OFF_PROCTRIG, {28'h0, trg});
    repeat (40) @(posedge clk_sys);
  endtask
  // Comparator pass: result, fault count, status, then clear status
  task automatic cmp(input logic [11:0] v, input int ef, input logic [31:0] es);
    run(v, 4'h1);
    chk("faults", nFault, ef);
    chk("cmpirq", cmpIrq, es[0]);
    rd(`ADCSQ_OFF_CMPSTS, es, "cmpsts");
    wr(`ADCSQ_OFF_CMPSTS, 32'hF);
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    close_out();
  end
  // Scenarios
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(8'h58, 32'h10, "cfg1");
    wr(8'h40, 32'h83);
    wr(8'h44, 32'h202);
    wr(`ADCSQ_OFF_ENABLE, 32'h9);
    wr(`ADCSQ_OFF_IRQMASK, 32'h1);
    run(12'h5A0, 4'h1);
    chk("seqirq", seqIrq, 32'h1);
    rd(8'h4C, 32'h5A3, "fifo");
    rd(8'h4C, 32'h5A8, "fifo");
    rd(8'h4C, 32'h0, "fifo");
    rd(`ADCSQ_OFF_UNF, 32'h1, "unf");
    rd(`ADCSQ_OFF_IRQMSK, 32'h1, "masked");
    wr(`ADCSQ_OFF_IRQRAW, 32'h1);
    @(posedge clk_sys);
    chk("seqirq", seqIrq, 32'h0);
    wr(`ADCSQ_OFF_IRQMASK, 32'h0);
    wr(`ADCSQ_OFF_AVG, 32'h2);
    run(12'h0F0, 4'h1);
    rd(8'h4C, 32'h0F3, "avg");
    rd(8'h4C, 32'h0F8, "avg");
    rd(`ADCSQ_OFF_IRQRAW, 32'h1, "raw");
    chk("seqirq", seqIrq, 32'h0);
    wr(`ADCSQ_OFF_AVG, 32'h0);
    chq.delete();
    run(12'h000, 4'h2);
    chk("idle", chq.size(), 32'h0);
    wr(8'h50, 32'h1);
    wr(8'h54, 32'h1);
    wr(8'h58, 32'h30);
    wr(8'h60, 32'h2);
    wr(8'h64, 32'h1);
    wr(8'h68, 32'h0);
    wr(`ADCSQ_OFF_ENABLE, 32'hF);
    run(12'h000, 4'h6);
    chk("first", chq[0], 32'h2);
    rd(8'h58, 32'h1_0030, "count1");
    wr(8'h74, 32'h1);
    run(12'h000, 4'h8);
    run(12'h000, 4'h8);
    rd(`ADCSQ_OFF_OVF, 32'h8, "ovf");
    wr(`ADCSQ_OFF_OVF, 32'h8);
    rd(`ADCSQ_OFF_OVF, 32'h0, "ovf");
    wr(8'h78, 32'h2);
    rd(8'h7C, 32'h0, "pop3");
    cval = 12'h123;
    extTrig <= 4'h1;
    repeat (40) @(posedge clk_sys);
    rd(8'h7C, 32'h123, "ext");
    wr(8'h78, 32'h1);
    repeat (20) @(posedge clk_sys);
    rd(`ADCSQ_OFF_OVF, 32'h8, "always");
    wr(`ADCSQ_OFF_ENABLE, 32'h1);
    wr(8'h40, 32'h0);
    wr(8'h44, 32'h1_0001);
    wr(8'h84, 32'h0300_0100);
    wr(8'h80, 32'h601);
    nFault = 0;
    cmp(12'h100, 1, 32'h0);
    cmp(12'h101, 1, 32'h1);
    cmp(12'h300, 1, 32'h0);
    wr(`ADCSQ_OFF_CMPRST, 32'h100);
    cmp(12'h200, 1, 32'h1);
    cmp(12'h0FF, 2, 32'h0);
    wr(8'h80, 32'h3);
    wr(`ADCSQ_OFF_CMPRST, 32'h1);
    cmp(12'h050, 3, 32'h0);
    cmp(12'h050, 3, 32'h0);
    cmp(12'h400, 3, 32'h0);
    cmp(12'h050, 4, 32'h0);
    wr(8'h80, 32'h0);
    cmp(12'h050, 4, 32'h0);
    wr(8'h80, 32'hA);
    wr(`ADCSQ_OFF_CMPRST, 32'h1);
    cmp(12'h400, 5, 32'h0);
    cmp(12'h050, 5, 32'h0);
    cmp(12'h400, 6, 32'h0);
    close_out();
  end
endmodule
